// File: srcs_consts.vh
// Constants of the shared register bank and lane select
`ifndef SRCS_CONSTS_VH
`define SRCS_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SRCS_ADDR_STRAP 8'h00
`define SRCS_ADDR_VERSION 8'h01
`define SRCS_ADDR_RSVD02 8'h02
`define SRCS_ADDR_RSVD03 8'h03
`define SRCS_ADDR_CTRL 8'h04
`define SRCS_ADDR_STAT 8'h05
`define SRCS_ADDR_RSVD06 8'h06
`define SRCS_ADDR_RSVD07 8'h07
`define SRCS_ADDR_SELECT 8'hFF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SRCS_RST_RSVD02 8'h00
`define SRCS_RST_RSVD06 8'h00
`define SRCS_RST_RSVD07 8'h05
`define SRCS_RST_CTRL_KEEP 5'h01
`define SRCS_RST_STAT_KEEP 2'h0
`define SRCS_RST_SELECT 4'h0
`define SRCS_RST_DONE 1'h1
`define SRCS_RD_INVALID 8'h00
`define SRCS_ZERO8 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SRCS_CTRL_RSVD7 7
`define SRCS_CTRL_SHRST 6
`define SRCS_CTRL_MSRST 5
`define SRCS_CTRL_FORCE 4
`define SRCS_STAT_DIS 7
`define SRCS_STAT_DONE 4
`define SRCS_SEL_BCAST 3
`define SRCS_SEL_EN 2
`define SRCS_SEL_IDX_HI 1
`define SRCS_SEL_IDX_LO 0
`define SRCS_LANES 4

`endif

// File: srcs_sel_decode.v
// Lane select decoder: turns the select value into write and read targets
`timescale 1ns/10ps
`include "srcs_consts.vh"

module srcs_sel_decode (
  // Select value
  input wire [3:0] sel,
  // Decoded targets
  output wire lane_bank_enable,
  output wire broadcast_write,
  output wire [1:0] lane_target_index,
  output wire [3:0] wr_mask
);

  assign lane_bank_enable = sel[`SRCS_SEL_EN];
  assign broadcast_write = sel[`SRCS_SEL_BCAST];
  assign lane_target_index = sel[`SRCS_SEL_IDX_HI:`SRCS_SEL_IDX_LO];

  // ----------------------------------------------------------------
  // Per-lane write enable
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `SRCS_LANES; i = i + 1)
    begin : g_mask
      localparam [1:0] LANE = i;
      assign wr_mask[i] = lane_bank_enable &
        (broadcast_write | (lane_target_index == LANE));
    end
  endgenerate

endmodule // srcs_sel_decode

// File: srcs_lane_flags.v
// Sticky per-lane interrupt flags, cleared by a read of the status register
`timescale 1ns/10ps
`include "srcs_consts.vh"

module srcs_lane_flags (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire soft_clr,
  input wire rd_clr,
  input wire [3:0] lane_irq,
  // Flags
  output wire [3:0] flags
);

  reg [3:0] flag_q;

  // ----------------------------------------------------------------
  // Set wins over clear
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `SRCS_LANES; i = i + 1)
    begin : g_flag
      always @(posedge clk)
      begin
        if (!rst_n)
          flag_q[i] <= 1'b0;
        else if (lane_irq[i])
          flag_q[i] <= 1'b1;
        else if (soft_clr || rd_clr)
          flag_q[i] <= 1'b0;
      end
    end
  endgenerate

  assign flags = flag_q;

endmodule // srcs_lane_flags

// File: srcs_shared_regs.v
// Shared register bank with lane select and channel register steering
//
// Contract
// - Bit 6 of 0x04 restores shared defaults
// - Bit 5 of 0x04 resets master logic
// - Bit 4 of 0x04 forces EEPROM load
// - Bit 7 of 0x05 blocks EEPROM load
// - Bit 4 of 0x05 shows load done
// - Bits 3:0 of 0x05 flag lane interrupts
// - Broadcast plus enable writes all four lanes
// - Lane reads use select bits 1:0 only
// - Enable bit 0 sends everything to shared
// - Address 0xff write always updates select
// - Select register reads back invalid
// - Select values map shared, lane, broadcast
// - Selection persists until next 0xff write
// - Writes to read-only bits are ignored
`timescale 1ns/10ps
`include "srcs_consts.vh"

module srcs_shared_regs #(
  parameter [7:0] VERSION_ID = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register access from the serial target engine
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg reg_rvalid_q,
  // Address strap
  input wire [3:0] addr_strap,
  // Channel register sets
  output reg [3:0] ch_wr_q,
  output reg ch_rd_q,
  output reg [1:0] ch_rd_lane_q,
  output reg [7:0] ch_addr_q,
  output reg [7:0] ch_wdata_q,
  input wire [7:0] ch0_rdata,
  input wire [7:0] ch1_rdata,
  input wire [7:0] ch2_rdata,
  input wire [7:0] ch3_rdata,
  // Lane interrupt events
  input wire [3:0] lane_irq,
  // EEPROM loader
  input wire eeprom_load_done,
  output reg force_config_load_q,
  output reg eeprom_load_req_q,
  output reg config_load_disable_q,
  // Soft reset pulses
  output reg shared_regs_soft_reset_q,
  output reg master_mode_soft_reset_q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [3:0] sel_q;
  reg [3:0] strap_q;
  reg [7:0] rsvd02_q;
  reg [7:0] rsvd06_q;
  reg [7:0] rsvd07_q;
  reg [4:0] ctrl_keep_q;
  reg [1:0] stat_keep_q;
  reg done_q;
  reg rd_shared_q;
  reg [7:0] rd_addr_q;
  reg lane_bank_enable_q;

  wire lane_bank_enable;
  wire broadcast_write;
  wire [1:0] lane_target_index;
  wire [3:0] wr_mask;
  wire [3:0] flags;
  wire sel_hit;
  wire shared_wr;
  wire shared_rd;
  wire lane_rd;
  wire ctrl_wr;
  wire stat_rd;
  wire [7:0] ctrl_image;
  wire [7:0] stat_image;
  wire soft_clr;
  wire force_rise;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign sel_hit = (reg_addr == `SRCS_ADDR_SELECT);
  assign shared_wr = reg_wr && !sel_hit && !lane_bank_enable;
  assign shared_rd = rd_shared_q && !lane_bank_enable_q;
  assign lane_rd = reg_rd && lane_bank_enable && !sel_hit;
  assign ctrl_wr = shared_wr && (reg_addr == `SRCS_ADDR_CTRL);
  // Flags clear at the edge that captures them, so none is lost
  assign stat_rd = shared_rd && (rd_addr_q == `SRCS_ADDR_STAT);
  assign soft_clr = shared_regs_soft_reset_q;
  assign force_rise = ctrl_wr && reg_wdata[`SRCS_CTRL_FORCE] && !force_config_load_q;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  srcs_sel_decode u_dec (
    .sel(sel_q),
    .lane_bank_enable(lane_bank_enable),
    .broadcast_write(broadcast_write),
    .lane_target_index(lane_target_index),
    .wr_mask(wr_mask)
  );

  srcs_lane_flags u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .soft_clr(soft_clr),
    .rd_clr(stat_rd),
    .lane_irq(lane_irq),
    .flags(flags)
  );

  // ----------------------------------------------------------------
  // Read images of the mixed registers
  // ----------------------------------------------------------------
  assign ctrl_image = {ctrl_keep_q[4], 2'b00, force_config_load_q,
    ctrl_keep_q[3:0]};
  assign stat_image = {config_load_disable_q, stat_keep_q, done_q,
    flags[0], flags[1], flags[2], flags[3]};

  // ----------------------------------------------------------------
  // Select register
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
      sel_q <= `SRCS_RST_SELECT;
    // Upper nibble is not stored
    else if (reg_wr && sel_hit)
      sel_q <= reg_wdata[3:0];
  end

  // ----------------------------------------------------------------
  // Strap sampled on every clock after reset release
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
      strap_q <= 4'h0;
    else
      strap_q <= addr_strap;
  end

  // ----------------------------------------------------------------
  // Self-clearing reset pulses
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      shared_regs_soft_reset_q <= 1'b0;
      master_mode_soft_reset_q <= 1'b0;
    end
    else
    begin
      shared_regs_soft_reset_q <= ctrl_wr && reg_wdata[`SRCS_CTRL_SHRST];
      master_mode_soft_reset_q <= ctrl_wr && reg_wdata[`SRCS_CTRL_MSRST];
    end
  end

  // ----------------------------------------------------------------
  // Read-write shared registers
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n || soft_clr)
    begin
      rsvd02_q <= `SRCS_RST_RSVD02;
      rsvd06_q <= `SRCS_RST_RSVD06;
      rsvd07_q <= `SRCS_RST_RSVD07;
      ctrl_keep_q <= `SRCS_RST_CTRL_KEEP;
      stat_keep_q <= `SRCS_RST_STAT_KEEP;
      force_config_load_q <= 1'b0;
      config_load_disable_q <= 1'b0;
    end
    else if (shared_wr)
    begin
      case (reg_addr)
        `SRCS_ADDR_RSVD02: rsvd02_q <= reg_wdata;
        `SRCS_ADDR_RSVD06: rsvd06_q <= reg_wdata;
        `SRCS_ADDR_RSVD07: rsvd07_q <= reg_wdata;
        `SRCS_ADDR_CTRL:
        begin
          ctrl_keep_q <= {reg_wdata[`SRCS_CTRL_RSVD7], reg_wdata[3:0]};
          force_config_load_q <= reg_wdata[`SRCS_CTRL_FORCE];
        end
        `SRCS_ADDR_STAT:
        begin
          config_load_disable_q <= reg_wdata[`SRCS_STAT_DIS];
          stat_keep_q <= reg_wdata[6:5];
        end
        default:
        begin
          rsvd02_q <= rsvd02_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // EEPROM load request and done status
  // ----------------------------------------------------------------
  // Request only on a 0 to 1 change of the force bit
  always @(posedge clk)
  begin
    if (!rst_n)
      eeprom_load_req_q <= 1'b0;
    else
      eeprom_load_req_q <= force_rise && !soft_clr && !config_load_disable_q;
  end

  always @(posedge clk)
  begin
    if (!rst_n || soft_clr)
      done_q <= `SRCS_RST_DONE;
    else if (eeprom_load_done)
      done_q <= 1'b1;
    else if (eeprom_load_req_q)
      done_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Channel steering
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ch_wr_q <= 4'h0;
      ch_rd_q <= 1'b0;
      ch_rd_lane_q <= 2'h0;
      ch_addr_q <= `SRCS_ZERO8;
      ch_wdata_q <= `SRCS_ZERO8;
    end
    else
    begin
      ch_wr_q <= (reg_wr && !sel_hit) ? wr_mask : 4'h0;
      ch_rd_q <= lane_rd;
      ch_rd_lane_q <= lane_target_index;
      ch_addr_q <= reg_addr;
      ch_wdata_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read pipeline
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_shared_q <= 1'b0;
      rd_addr_q <= `SRCS_ZERO8;
      lane_bank_enable_q <= 1'b0;
      reg_rvalid_q <= 1'b0;
      reg_rdata_q <= `SRCS_ZERO8;
    end
    else
    begin
      rd_shared_q <= reg_rd;
      rd_addr_q <= reg_addr;
      lane_bank_enable_q <= lane_bank_enable;
      reg_rvalid_q <= rd_shared_q;
      if (!rd_shared_q)
        reg_rdata_q <= reg_rdata_q;
      else if (rd_addr_q == `SRCS_ADDR_SELECT)
        reg_rdata_q <= `SRCS_RD_INVALID;
      else if (lane_bank_enable_q)
      begin
        case (ch_rd_lane_q)
          2'h0: reg_rdata_q <= ch0_rdata;
          2'h1: reg_rdata_q <= ch1_rdata;
          2'h2: reg_rdata_q <= ch2_rdata;
          default: reg_rdata_q <= ch3_rdata;
        endcase
      end
      else
      begin
        case (rd_addr_q)
          `SRCS_ADDR_STRAP: reg_rdata_q <= {strap_q, 4'h0};
          `SRCS_ADDR_VERSION: reg_rdata_q <= VERSION_ID;
          `SRCS_ADDR_RSVD02: reg_rdata_q <= rsvd02_q;
          `SRCS_ADDR_CTRL: reg_rdata_q <= ctrl_image;
          `SRCS_ADDR_STAT: reg_rdata_q <= stat_image;
          `SRCS_ADDR_RSVD06: reg_rdata_q <= rsvd06_q;
          `SRCS_ADDR_RSVD07: reg_rdata_q <= rsvd07_q;
          default: reg_rdata_q <= `SRCS_ZERO8;
        endcase
      end
    end
  end

endmodule // srcs_shared_regs

// File: srcs_checker.sv
// Assertion checker for the shared register bank
`timescale 1ns/10ps
module srcs_checker (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Host side
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire reg_rvalid_q,
  // Lane and loader side
  input wire [3:0] ch_wr_q,
  input wire ch_rd_q,
  input wire [1:0] ch_rd_lane_q,
  input wire force_config_load_q,
  input wire eeprom_load_req_q,
  input wire config_load_disable_q,
  input wire shared_regs_soft_reset_q,
  input wire master_mode_soft_reset_q
);
  reg [3:0] sel_q;
  wire ff = reg_addr == 8'hFF;
  wire ctl = reg_wr && !sel_q[2] && reg_addr == 8'h04;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // Shadow of the select value
  // ------------------------------
  always @(posedge clk)
    if (!rst_n)
      sel_q <= 4'h0;
    else if (reg_wr && ff)
      sel_q <= reg_wdata[3:0];
  sel_unread_a: assert property (reg_rd && ff |-> ##2 reg_rvalid_q && reg_rdata_q == 8'h00)
    else $error("select read not zero");
  bcast_wr_a: assert property (reg_wr && !ff && sel_q[3:2] == 2'b11 |=> ch_wr_q == 4'hF)
    else $error("broadcast missed a lane");
  lane_wr_a: assert property (reg_wr && !ff && sel_q[3:2] == 2'b01 |=> ch_wr_q == 4'h1 << sel_q[1:0])
    else $error("lane write strobe wrong");
  shared_only_a: assert property (!sel_q[2] |=> ch_wr_q == 4'h0 && !ch_rd_q)
    else $error("lane access while disabled");
  lane_rd_a: assert property (reg_rd && !ff && sel_q[2] |=> ch_rd_q && ch_rd_lane_q == sel_q[1:0])
    else $error("lane read target wrong");
  shared_rst_a: assert property (ctl && reg_wdata[6] |=> shared_regs_soft_reset_q ##1 !shared_regs_soft_reset_q)
    else $error("shared reset pulse wrong");
  master_rst_a: assert property (ctl && reg_wdata[5] |=> master_mode_soft_reset_q ##1 !master_mode_soft_reset_q)
    else $error("master reset pulse wrong");
  load_gate_a: assert property (eeprom_load_req_q |-> force_config_load_q && !$past(force_config_load_q) && !$past(config_load_disable_q))
    else $error("load request without cause");
  bcast_c: cover property (reg_wr && !ff && sel_q[3:2] == 2'b11);
  load_c: cover property (eeprom_load_req_q);
  shrst_c: cover property (shared_regs_soft_reset_q);
endmodule // srcs_checker

bind srcs_shared_regs srcs_checker u_chk (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .ch_wr_q(ch_wr_q), .ch_rd_q(ch_rd_q),
  .ch_rd_lane_q(ch_rd_lane_q), .force_config_load_q(force_config_load_q),
  .eeprom_load_req_q(eeprom_load_req_q), .config_load_disable_q(config_load_disable_q),
  .shared_regs_soft_reset_q(shared_regs_soft_reset_q),
  .master_mode_soft_reset_q(master_mode_soft_reset_q));

// File: srcs_lane_model.sv
// Behavioural lane register sets and configuration loader
`timescale 1ns/10ps
module srcs_lane_model #(
  parameter int LOAD_CYC = 20
) (
  // Clock
  input wire clk,
  // From the bank
  input wire [3:0] ch_wr_q,
  input wire [7:0] ch_addr_q,
  input wire [7:0] ch_wdata_q,
  input wire eeprom_load_req_q,
  // To the bank
  output logic [7:0] ch0_rdata,
  output logic [7:0] ch1_rdata,
  output logic [7:0] ch2_rdata,
  output logic [7:0] ch3_rdata,
  output logic eeprom_load_done
);
  logic [7:0] mem [0:3][0:255];
  int cnt = 0;
  initial eeprom_load_done = 1'b0;
  initial foreach (mem[i, j]) mem[i][j] = 8'h00;
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
      if (ch_wr_q[i])
        mem[i][ch_addr_q] <= ch_wdata_q;
    eeprom_load_done <= cnt == 1;
    if (eeprom_load_req_q)
      cnt <= LOAD_CYC;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign ch0_rdata = mem[0][ch_addr_q];
  assign ch1_rdata = mem[1][ch_addr_q];
  assign ch2_rdata = mem[2][ch_addr_q];
  assign ch3_rdata = mem[3][ch_addr_q];
endmodule // srcs_lane_model

// File: shared_regs_channel_select_tb_top.sv
// Self-checking bench for the shared register bank
`timescale 1ns/10ps
module shared_regs_channel_select_tb_top;
  localparam logic [7:0] VER = 8'h3C; // Arbitrary value
  logic clk, rst_n, reg_wr, reg_rd, done;
  logic [7:0] reg_addr, reg_wdata, a, d;
  logic [3:0] addr_strap, lane_irq, sel, flg;
  wire [7:0] reg_rdata_q, ch_addr_q, ch_wdata_q;
  wire [7:0] ch0_rdata, ch1_rdata, ch2_rdata, ch3_rdata;
  wire [3:0] ch_wr_q;
  wire [1:0] ch_rd_lane_q;
  wire reg_rvalid_q, ch_rd_q, ld_done, ld_req;
  logic [7:0] sh [0:7];
  logic [7:0] lm [0:3][0:255];
  int n_errors = 0, n_checks = 0, cyc = 0;
  srcs_shared_regs #(.VERSION_ID(VER)) u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .addr_strap(addr_strap), .ch_wr_q(ch_wr_q), .ch_rd_q(ch_rd_q),
    .ch_rd_lane_q(ch_rd_lane_q), .ch_addr_q(ch_addr_q), .ch_wdata_q(ch_wdata_q),
    .ch0_rdata(ch0_rdata), .ch1_rdata(ch1_rdata), .ch2_rdata(ch2_rdata), .ch3_rdata(ch3_rdata),
    .lane_irq(lane_irq), .eeprom_load_done(ld_done), .force_config_load_q(),
    .eeprom_load_req_q(ld_req), .config_load_disable_q(), .shared_regs_soft_reset_q(),
    .master_mode_soft_reset_q());
  srcs_lane_model #(.LOAD_CYC(20)) u_lane (.clk(clk), .ch_wr_q(ch_wr_q), .ch_addr_q(ch_addr_q),
    .ch_wdata_q(ch_wdata_q), .eeprom_load_req_q(ld_req), .ch0_rdata(ch0_rdata),
    .ch1_rdata(ch1_rdata), .ch2_rdata(ch2_rdata), .ch3_rdata(ch3_rdata),
    .eeprom_load_done(ld_done));
  // ------------------------------
  // Reference model and bus tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic dflt;
    sh[2] = 8'h00; sh[4] = 8'h01; sh[5] = 8'h00; sh[6] = 8'h00; sh[7] = 8'h05;
    done = 1'b1; flg = 4'h0;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] x);
    if (x == 8'hFF) return 8'h00;
    if (sel[2]) return lm[sel[1:0]][x];
    case (x)
      8'h00: return {addr_strap, 4'h0};
      8'h01: return VER;
      8'h02, 8'h04, 8'h06, 8'h07: return sh[x[2:0]];
      8'h05: return {sh[5][7:5], done, flg};
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [7:0] x, input logic [7:0] v);
    @(posedge clk); reg_wr <= 1'b1; reg_addr <= x; reg_wdata <= v;
    @(posedge clk); reg_wr <= 1'b0;
    if (x == 8'hFF) sel = v[3:0];
    else if (sel[2])
    begin
      for (int i = 0; i < 4; i++) if (sel[3] || sel[1:0] == i) lm[i][x] = v;
    end
    else if (x == 8'h04 && v[6]) dflt();
    else if (x == 8'h04)
    begin
      if (v[4] && !sh[4][4] && !sh[5][7]) done = 1'b0;
      sh[4] = v & 8'h9F;
    end
    else if (x == 8'h05) sh[5] = v & 8'hE0;
    else if (x == 8'h02 || x == 8'h06 || x == 8'h07) sh[x[2:0]] = v;
  endtask
  task automatic rd(input logic [7:0] x);
    logic [7:0] e;
    e = exp_rd(x);
    @(posedge clk); reg_rd <= 1'b1; reg_addr <= x;
    @(posedge clk); reg_rd <= 1'b0;
    @(posedge clk); #1;
    chk("rvalid", {7'h00, reg_rvalid_q}, 8'h01);
    chk("rdata", reg_rdata_q, e);
    if (x == 8'h05 && !sel[2]) flg = 4'h0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    lane_irq = 4'h0; addr_strap = 4'h0; sel = 4'h0; dflt();
    foreach (lm[i, j]) lm[i][j] = 8'h00;
    a = 8'($urandom(57));
    @(posedge clk); addr_strap <= 4'($urandom);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(8'(i));
    rd(8'hFF);
    $display("defaults done");
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom) & (i == 4 ? 8'h8F : 8'h7F);
      wr(8'(i), d);
      rd(8'(i));
    end
    $display("shared access done");
    for (int k = 0; k < 8; k++)
    begin
      wr(8'hFF, 8'(k < 4 ? 4 + k : 8 + k));
      a = 8'($urandom % 255); d = 8'($urandom);
      wr(a, d);
      rd(a);
      rd(8'hFF);
    end
    for (int i = 0; i < 4; i++) begin wr(8'hFF, 8'(4 + i)); rd(a); end
    wr(8'hFF, 8'h00); rd(8'h00); rd(8'h02);
    $display("lane select done");
    for (int i = 0; i < 4; i++) if (4'($urandom) & (4'h1 << i))
    begin
      @(posedge clk); lane_irq <= 4'h1 << i; @(posedge clk); lane_irq <= 4'h0;
      flg[3 - i] = 1'b1;
    end
    rd(8'h05); rd(8'h05);
    $display("lane flags done");
    wr(8'h02, 8'hAA); wr(8'h04, 8'h40); repeat (2) @(posedge clk);
    for (int i = 2; i < 8; i++) rd(8'(i));
    wr(8'h04, 8'h20); rd(8'h04);
    $display("soft reset done");
    wr(8'h04, 8'h11); repeat (3) @(posedge clk); rd(8'h05);
    repeat (30) @(posedge clk); done = 1'b1; rd(8'h05);
    wr(8'h04, 8'h01); wr(8'h05, 8'h80); wr(8'h04, 8'h11);
    repeat (5) @(posedge clk); rd(8'h05); rd(8'h04);
    $display("config load done");
    summarize();
  end
endmodule // shared_regs_channel_select_tb_top
